// ---- pci_dma_regs.vh ----
/*
 * Register offsets, field positions, reset values and encodings of the
 * single-channel PCI DMA engine.
 * Assumes it is included by bare name from the design files; it holds
 * definitions only.
 */
`ifndef PCI_DMA_REGS_VH
`define PCI_DMA_REGS_VH

// Register byte addresses on the register port
`define OFF_CFG 8'h00
`define OFF_STATUS 8'h04
`define OFF_SBA_LO 8'h08
`define OFF_SBA_HI 8'h0C
`define OFF_PCA_LO 8'h10
`define OFF_PCA_HI 8'h14
`define OFF_COUNT 8'h18
`define OFF_CHAIN_LO 8'h1C
`define OFF_CHAIN_HI 8'h20

// Channel configuration register fields
`define CFG_CHANNEL_RESET_BIT 0
`define CFG_DIR 1
`define CFG_SIZE_LO 2
`define CFG_SIZE_HI 3
`define CFG_TRANSFER_ACTIVE_BIT 4
`define CFG_NTIE 8
`define CFG_NCIE 9
`define CFG_ERROR_IRQ_ENABLE 10
`define CFG_RESET 32'h0000_0001
`define CFG_WMASK 32'h0000_070F

// Channel status register fields
`define ERR_CFG 0
`define ERR_PCI 1
`define ERR_CHAIN 2
`define ERR_DATA 3
`define ERR_TARGET 4
`define ST_TRANSFER_DONE_FLAG 8
`define ST_CHAIN_DONE_FLAG 9
`define ST_BUSY 16
`define STATUS_RESET 10'h000

// Transfer unit sizes
`define SIZE_DWORD 2'h0
`define SIZE_QWORD 2'h1
`define SIZE_BURST 2'h2

// Descriptor field offsets
`define DESC_LINK 36'h0_0000_0000
`define DESC_SBA 36'h0_0000_0008
`define DESC_PCA 36'h0_0000_0010
`define DESC_CNT 36'h0_0000_0018

// Reachable system-bus window (the SDRAM controller)
`define SDRAM_BASE 64'h0000_0000_0000_0000
`define SDRAM_LIMIT 64'h0000_0000_FFFF_FFFF

`endif

// ---- pin_sync3.v ----
/*
 * Three-flop synchronisers for the pins that come from the PCI clock
 * domain (PCI clock, handshake acknowledge, error).
 * Assumes core_clk is much faster than the PCI clock; a level is taken
 * once the second and third flops agree.
 */
`timescale 1ns/1ps

module pin_sync3 (
    input wire core_clk,
    input wire rst_n,
    input wire [2:0] async_in,
    output wire [2:0] level,
    output wire [2:0] rise
);

genvar i;
generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_bit
        reg s1_q;
        reg s2_q;
        reg s3_q;
        reg lvl_q;
        reg rise_q;
        always @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                s3_q <= 1'b0;
                lvl_q <= 1'b0;
                rise_q <= 1'b0;
            end
            else
            begin
                s1_q <= async_in[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
                // Only an agreed value moves the level
                if (s2_q == s3_q)
                    lvl_q <= s3_q;
                rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
            end
        end
        assign level[i] = lvl_q;
        assign rise[i] = rise_q;
    end
endgenerate

endmodule // pin_sync3

// ---- pci_dma_channel.v ----
/*
 * Single-channel DMA engine between the system bus (data in SDRAM only; descriptor reads are not window-checked) and the
 * PCI side, with register-programmed and descriptor-chained transfers.
 * Assumes a one-cycle register port, a system-bus slave answering with a
 * one-cycle mem_ack, and a four-phase req/ack handshake on the PCI side.
 */
`timescale 1ns/1ps
`include "pci_dma_regs.vh"

module pci_dma_channel (
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg mem_req,
    output reg mem_we,
    output reg [35:0] mem_addr,
    output reg [7:0] mem_be,
    output reg [63:0] mem_wdata,
    input wire [63:0] mem_rdata,
    input wire mem_ack,
    input wire mem_err,
    input wire pci_clk,
    output reg pci_req,
    output reg pci_we,
    output reg [63:0] pci_addr,
    output reg [31:0] pci_wdata,
    input wire [31:0] pci_rdata,
    input wire pci_ack,
    input wire pci_err,
    output reg dma_irq
);

localparam [3:0] S_IDLE = 4'h0;
localparam [3:0] S_FETCH = 4'h1;
localparam [3:0] S_CHECK = 4'h2;
localparam [3:0] S_MRD = 4'h3;
localparam [3:0] S_PREQ = 4'h4;
localparam [3:0] S_PWAIT = 4'h5;
localparam [3:0] S_PDONE = 4'h6;
localparam [3:0] S_MWR = 4'h7;
localparam [3:0] S_ADV = 4'h8;
localparam [3:0] S_END = 4'h9;

reg [31:0] cfg_q;
reg [9:0] status_q;
reg [63:0] sba_q;
reg [63:0] pca_q;
reg [31:0] cnt_q;
reg [63:0] chain_q;
reg [35:0] desc_base_q;
reg [3:0] state_q;
reg [1:0] didx_q;
reg widx_q;
reg chain_mode_q;
reg last_q;
reg perr_q;
reg [63:0] buf_q;
reg [4:0] err_set_q;
reg nt_set_q;
reg nc_set_q;
wire [2:0] sync_lvl;
wire [2:0] sync_rise;
wire pclk_rise;
wire ack_lvl;
wire err_lvl;
wire channel_reset_bit;
wire dir_in;
wire [1:0] unit;
wire dword;
wire [31:0] chunk;
wire [63:0] end_addr;
wire cfg_bad;
wire tgt_bad;
wire busy;
wire [63:0] chain_new;

////////////////////////////////////////////////////////////////////////
// PCI-domain pins: clock edges and handshake levels
pin_sync3 u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({pci_err, pci_ack, pci_clk}),
    .level(sync_lvl),
    .rise(sync_rise)
);

assign pclk_rise = sync_rise[0];
assign ack_lvl = sync_lvl[1];
assign err_lvl = sync_lvl[2];

assign channel_reset_bit = cfg_q[`CFG_CHANNEL_RESET_BIT];
assign dir_in = cfg_q[`CFG_DIR];
assign unit = cfg_q[`CFG_SIZE_HI:`CFG_SIZE_LO];
assign dword = (unit == `SIZE_DWORD);
assign chunk = dword ? 32'h0000_0004 : 32'h0000_0008;
assign end_addr = sba_q + {32'h0000_0000, cnt_q} - 64'h0000_0000_0000_0001;
// Misaligned wide units are refused rather than split
assign cfg_bad = (cnt_q[1:0] != 2'h0) ||
    (!dword && ((sba_q[2:0] | pca_q[2:0] | cnt_q[2:0]) != 3'h0));
assign tgt_bad = (sba_q < `SDRAM_BASE) || (end_addr > `SDRAM_LIMIT);
assign busy = (state_q != S_IDLE);
assign chain_new = {chain_q[63:32], reg_wdata};

////////////////////////////////////////////////////////////////////////
// Register writes, descriptor loads and the transfer sequencer
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        cfg_q <= `CFG_RESET;
        sba_q <= 64'h0000_0000_0000_0000;
        pca_q <= 64'h0000_0000_0000_0000;
        cnt_q <= 32'h0000_0000;
        chain_q <= 64'h0000_0000_0000_0000;
        desc_base_q <= 36'h0_0000_0000;
        state_q <= S_IDLE;
        didx_q <= 2'h0;
        widx_q <= 1'b0;
        chain_mode_q <= 1'b0;
        last_q <= 1'b0;
        perr_q <= 1'b0;
        buf_q <= 64'h0000_0000_0000_0000;
        err_set_q <= 5'h00;
        nt_set_q <= 1'b0;
        nc_set_q <= 1'b0;
        mem_req <= 1'b0;
        mem_we <= 1'b0;
        mem_addr <= 36'h0_0000_0000;
        mem_be <= 8'h00;
        mem_wdata <= 64'h0000_0000_0000_0000;
        pci_req <= 1'b0;
        pci_we <= 1'b0;
        pci_addr <= 64'h0000_0000_0000_0000;
        pci_wdata <= 32'h0000_0000;
    end
    else
    begin
        err_set_q <= 5'h00;
        nt_set_q <= 1'b0;
        nc_set_q <= 1'b0;
        if (reg_wr)
        begin
            case (reg_addr)
                `OFF_CFG: cfg_q <= reg_wdata & `CFG_WMASK;
                `OFF_SBA_LO: sba_q[31:0] <= reg_wdata;
                `OFF_SBA_HI: sba_q[63:32] <= reg_wdata;
                `OFF_PCA_LO: pca_q[31:0] <= reg_wdata;
                `OFF_PCA_HI: pca_q[63:32] <= reg_wdata;
                `OFF_COUNT: cnt_q <= reg_wdata;
                `OFF_CHAIN_HI: chain_q[63:32] <= reg_wdata;
                `OFF_CHAIN_LO: chain_q[31:0] <= reg_wdata;
                default: ;
            endcase
        end
        if (reg_wr && (reg_addr == `OFF_CFG) && reg_wdata[`CFG_TRANSFER_ACTIVE_BIT] &&
            !reg_wdata[`CFG_CHANNEL_RESET_BIT] && !busy)
        begin
            chain_mode_q <= 1'b0;
            last_q <= 1'b1;
            state_q <= S_CHECK;
        end
        // Zero test happens only here, on the low-half write
        if (reg_wr && (reg_addr == `OFF_CHAIN_LO) && (chain_new != 64'h0000_0000_0000_0000) &&
            !channel_reset_bit && !busy)
        begin
            chain_mode_q <= 1'b1;
            desc_base_q <= chain_new[35:0];
            didx_q <= 2'h0;
            state_q <= S_FETCH;
        end
        if (channel_reset_bit)
        begin
            // Channel reset drops any handshake in flight
            state_q <= S_IDLE;
            mem_req <= 1'b0;
            pci_req <= 1'b0;
        end
        else
        begin
            case (state_q)
                S_IDLE: ;
                S_FETCH:
                begin
                    // Four single qword reads of the descriptor
                    if (!mem_req)
                    begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_be <= 8'hFF;
                        case (didx_q)
                            2'h0: mem_addr <= desc_base_q + `DESC_LINK;
                            2'h1: mem_addr <= desc_base_q + `DESC_SBA;
                            2'h2: mem_addr <= desc_base_q + `DESC_PCA;
                            default: mem_addr <= desc_base_q + `DESC_CNT;
                        endcase
                    end
                    else if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        if (mem_err)
                        begin
                            err_set_q[`ERR_CHAIN] <= 1'b1;
                            state_q <= S_IDLE;
                        end
                        else
                        begin
                            case (didx_q)
                                2'h0:
                                begin
                                    // Zero link keeps the final descriptor address
                                    if (mem_rdata != 64'h0000_0000_0000_0000)
                                        chain_q <= mem_rdata;
                                    last_q <= (mem_rdata == 64'h0000_0000_0000_0000);
                                end
                                2'h1: sba_q <= mem_rdata;
                                2'h2: pca_q <= mem_rdata;
                                default: cnt_q <= mem_rdata[31:0];
                            endcase
                            didx_q <= didx_q + 2'h1;
                            if (didx_q == 2'h3)
                                state_q <= S_CHECK;
                        end
                    end
                end
                S_CHECK:
                begin
                    widx_q <= 1'b0;
                    if (cfg_bad)
                    begin
                        err_set_q[`ERR_CFG] <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    else if (cnt_q == 32'h0000_0000)
                        state_q <= S_END;
                    else if (tgt_bad)
                    begin
                        err_set_q[`ERR_TARGET] <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    else
                        state_q <= dir_in ? S_PREQ : S_MRD;
                end
                S_MRD:
                begin
                    if (!mem_req)
                    begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= sba_q[35:0];
                        mem_be <= !dword ? 8'hFF : (sba_q[2] ? 8'hF0 : 8'h0F);
                    end
                    else if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        buf_q <= (dword && sba_q[2]) ? {32'h0000_0000, mem_rdata[63:32]} : mem_rdata;
                        if (mem_err)
                        begin
                            err_set_q[`ERR_DATA] <= 1'b1;
                            state_q <= S_IDLE;
                        end
                        else
                            state_q <= S_PREQ;
                    end
                end
                S_PREQ:
                begin
                    // Apart from a channel reset, PCI-side outputs move only just after a PCI clock rise
                    if (pclk_rise && !ack_lvl)
                    begin
                        pci_req <= 1'b1;
                        pci_we <= !dir_in;
                        pci_addr <= pca_q;
                        pci_wdata <= widx_q ? buf_q[63:32] : buf_q[31:0];
                        state_q <= S_PWAIT;
                    end
                end
                S_PWAIT:
                begin
                    if (ack_lvl && pclk_rise)
                    begin
                        pci_req <= 1'b0;
                        perr_q <= err_lvl;
                        if (widx_q)
                            buf_q[63:32] <= pci_rdata;
                        else
                            buf_q[31:0] <= pci_rdata;
                        state_q <= S_PDONE;
                    end
                end
                S_PDONE:
                begin
                    if (!ack_lvl)
                    begin
                        if (perr_q)
                        begin
                            err_set_q[`ERR_PCI] <= 1'b1;
                            state_q <= S_IDLE;
                        end
                        else
                        begin
                            pca_q <= pca_q + 64'h0000_0000_0000_0004;
                            widx_q <= !widx_q;
                            if (!dword && !widx_q)
                                state_q <= S_PREQ;
                            else
                                state_q <= dir_in ? S_MWR : S_ADV;
                        end
                    end
                end
                S_MWR:
                begin
                    if (!mem_req)
                    begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= sba_q[35:0];
                        mem_be <= !dword ? 8'hFF : (sba_q[2] ? 8'hF0 : 8'h0F);
                        mem_wdata <= (dword && sba_q[2]) ? {buf_q[31:0], 32'h0000_0000} : buf_q;
                    end
                    else if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        if (mem_err)
                        begin
                            err_set_q[`ERR_DATA] <= 1'b1;
                            state_q <= S_IDLE;
                        end
                        else
                            state_q <= S_ADV;
                    end
                end
                S_ADV:
                begin
                    sba_q <= sba_q + {32'h0000_0000, chunk};
                    cnt_q <= cnt_q - chunk;
                    widx_q <= 1'b0;
                    if (cnt_q == chunk)
                        state_q <= S_END;
                    else
                        state_q <= dir_in ? S_PREQ : S_MRD;
                end
                S_END:
                begin
                    nt_set_q <= 1'b1;
                    if (chain_mode_q && !last_q)
                    begin
                        desc_base_q <= chain_q[35:0];
                        didx_q <= 2'h0;
                        state_q <= S_FETCH;
                    end
                    else
                    begin
                        nc_set_q <= chain_mode_q;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Sticky status: a same-cycle set beats the write-one clear
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
        status_q <= `STATUS_RESET;
    else if (channel_reset_bit)
        status_q <= `STATUS_RESET;
    else
    begin
        if (reg_wr && (reg_addr == `OFF_STATUS))
            status_q <= (status_q & ~reg_wdata[9:0]) | {nc_set_q, nt_set_q, 3'h0, err_set_q};
        else
            status_q <= status_q | {nc_set_q, nt_set_q, 3'h0, err_set_q};
    end
end

////////////////////////////////////////////////////////////////////////
// Interrupt line and register reads
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        dma_irq <= 1'b0;
        reg_rdata <= 32'h0000_0000;
    end
    else
    begin
        dma_irq <= (status_q[`ST_TRANSFER_DONE_FLAG] && cfg_q[`CFG_NTIE]) ||
            (status_q[`ST_CHAIN_DONE_FLAG] && cfg_q[`CFG_NCIE]) ||
            ((status_q[4:0] != 5'h00) && cfg_q[`CFG_ERROR_IRQ_ENABLE]);
        if (reg_rd)
        begin
            case (reg_addr)
                `OFF_CFG: reg_rdata <= cfg_q | {27'h0, busy, 4'h0};
                `OFF_STATUS: reg_rdata <= {15'h0, busy, 6'h00, status_q};
                `OFF_SBA_LO: reg_rdata <= sba_q[31:0];
                `OFF_SBA_HI: reg_rdata <= sba_q[63:32];
                `OFF_PCA_LO: reg_rdata <= pca_q[31:0];
                `OFF_PCA_HI: reg_rdata <= pca_q[63:32];
                `OFF_COUNT: reg_rdata <= cnt_q;
                `OFF_CHAIN_LO: reg_rdata <= chain_q[31:0];
                `OFF_CHAIN_HI: reg_rdata <= chain_q[63:32];
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end
end

endmodule // pci_dma_channel

// ---- pci_dma_chk.sv ----
/* Port-timing checker for pci_dma_channel.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module pci_dma_chk (
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire mem_req,
    input wire mem_we,
    input wire [35:0] mem_addr,
    input wire [7:0] mem_be,
    input wire mem_ack,
    input wire pci_req,
    input wire [63:0] pci_addr,
    input wire [31:0] pci_wdata,
    input wire pci_ack,
    input wire dma_irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    sequence s_mem_wait;
        mem_req && !mem_ack;
    endsequence
    sequence s_pci_wait;
        pci_req && !pci_ack;
    endsequence
    property p_mem_hold;
        s_mem_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_be);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("mem request changed before ack");
    property p_mem_gap;
        mem_req && mem_ack |=> !mem_req;
    endproperty
    a_mem_gap: assert property (p_mem_gap) else $error("no idle cycle after mem ack");
    property p_mem_window;
        mem_req |-> mem_addr[35:32] == 4'h0;
    endproperty
    a_mem_window: assert property (p_mem_window) else $error("access outside sdram window");
    property p_mem_lanes;
        mem_req |-> mem_be == 8'hFF || mem_be == (mem_addr[2] ? 8'hF0 : 8'h0F);
    endproperty
    a_mem_lanes: assert property (p_mem_lanes) else $error("byte lanes do not match address");
    property p_pci_hold;
        s_pci_wait |=> pci_req && $stable(pci_addr) && $stable(pci_wdata);
    endproperty
    a_pci_hold: assert property (p_pci_hold) else $error("pci request changed before ack");
    property p_pci_drop;
        $fell(pci_req) |-> $past(pci_ack) || $past(reg_wr) || $past(reg_wr, 2);
    endproperty
    a_pci_drop: assert property (p_pci_drop) else $error("pci request dropped without ack");
    property p_channel_reset_bit;
        reg_wr && reg_addr == 8'h00 && reg_wdata[0] |-> ##3 !mem_req && !pci_req && !dma_irq;
    endproperty
    a_channel_reset_bit: assert property (p_channel_reset_bit) else $error("channel reset left engine active");
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
endmodule // pci_dma_chk

bind pci_dma_channel pci_dma_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_ack(mem_ack), .pci_req(pci_req),
    .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_ack(pci_ack), .dma_irq(dma_irq));

// ---- dma_far_side.sv ----
/* Far side of the channel: SDRAM slave on the system bus and a PCI agent.
   Assumes the bench fills mem and reads pci_log by hierarchical name. */
`timescale 1ns/1ps
module dma_far_side (
    input wire core_clk,
    input wire rst_n,
    input wire slow,
    input wire fail_mem,
    input wire fail_pci,
    input wire mem_req,
    input wire mem_we,
    input wire [35:0] mem_addr,
    input wire [7:0] mem_be,
    input wire [63:0] mem_wdata,
    output logic [63:0] mem_rdata,
    output logic mem_ack,
    output logic mem_err,
    output logic pci_clk,
    input wire pci_req,
    input wire pci_we,
    input wire [63:0] pci_addr,
    input wire [31:0] pci_wdata,
    output logic [31:0] pci_rdata,
    output logic pci_ack,
    output logic pci_err
);
    logic [63:0] mem [logic [32:0]];
    logic [63:0] pci_log [$];
    logic [63:0] q;
    logic [2:0] wait_cnt;
    logic pci_hold;

    function automatic logic [63:0] rd(input logic [32:0] k);
        rd = mem.exists(k) ? mem[k] : {31'h0, k} ^ 64'h0F0F_0000_0000_0000;
    endfunction
    ////////////////////////////////////////
    // Released data lines flip so a stale value is never mistaken for data
    always @(posedge core_clk or negedge rst_n)
        if (!rst_n)
        begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= 64'h0;
            wait_cnt <= 3'h0;
        end
        else if (mem_req && !mem_ack && wait_cnt >= (slow ? 3'h4 : 3'h1))
        begin
            mem_ack <= 1'b1;
            mem_err <= fail_mem;
            wait_cnt <= 3'h0;
            q = rd(mem_addr[35:3]);
            for (int i = 0; i < 8; i++)
                if (mem_we && mem_be[i])
                    q[i*8+:8] = mem_wdata[i*8+:8];
            mem[mem_addr[35:3]] = q;
            mem_rdata <= q;
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_err <= ~mem_err;
            mem_rdata <= ~mem_rdata;
            wait_cnt <= mem_req ? wait_cnt + 3'h1 : 3'h0;
        end

    initial
    begin
        pci_clk = 1'b0;
        #7;
        forever #40 pci_clk = ~pci_clk;
    end

    // Error level is set while idle so it is valid before ack rises
    always @(posedge pci_clk or negedge rst_n)
        if (!rst_n)
        begin
            pci_ack <= 1'b0;
            pci_err <= 1'b0;
            pci_rdata <= 32'h0;
            pci_hold <= 1'b0;
        end
        else if (pci_req && !pci_ack && pci_hold)
            pci_hold <= 1'b0;
        else if (pci_req && !pci_ack)
        begin
            pci_ack <= 1'b1;
            pci_rdata <= pci_addr[31:0] ^ 32'hA5A5_0000;
            if (pci_we)
                pci_log.push_back({pci_addr[31:0], pci_wdata});
        end
        else if (!pci_req && pci_ack)
        begin
            pci_ack <= 1'b0;
            pci_hold <= slow;
            pci_rdata <= ~pci_rdata;
        end
        else if (!pci_ack)
            pci_err <= fail_pci;
endmodule // dma_far_side

// ---- test_pci_dma_channel.sv ----
/* Self-checking bench for pci_dma_channel with its far-side model.
   Assumes the model's mem and pci_log are reachable under far. */
`timescale 1ns/1ps
`include "pci_dma_regs.vh"
module test_pci_dma_channel;
    logic core_clk, rst_n, reg_wr, reg_rd, slow, fail_mem, fail_pci;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, st;
    wire [31:0] reg_rdata, pci_wdata, pci_rdata;
    wire [63:0] mem_wdata, mem_rdata, pci_addr;
    wire [35:0] mem_addr;
    wire [7:0] mem_be;
    wire mem_req, mem_we, mem_ack, mem_err, pci_clk, pci_req, pci_we, pci_ack, pci_err, dma_irq;
    int error_cnt, total_checks;

    pci_dma_channel uut (.*);
    dma_far_side far (.*);
    ////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_st(input logic [31:0] m);
        int n;
        n = 0;
        st = 32'h0;
        while ((st & m) == 32'h0 && n < 300)
        begin
            rd(`OFF_STATUS, st);
            n++;
        end
        chk(n < 300, 1'b1);
    endtask
    // Chain mode starts from the pointer write instead of the active bit
    task automatic prog(input logic [31:0] sba, shi, pca, cnt, cfg, input logic chain);
        wr(`OFF_SBA_LO, sba);
        wr(`OFF_SBA_HI, shi);
        wr(`OFF_PCA_LO, pca);
        wr(`OFF_COUNT, cnt);
        wr(`OFF_CHAIN_HI, 32'h0);
        wr(`OFF_CHAIN_LO, 32'h0);
        wr(`OFF_STATUS, 32'h0000_031F);
        wr(`OFF_CFG, cfg);
        rd(`OFF_STATUS, st);
        chk(st, 32'h0);
        if (chain)
            wr(`OFF_CHAIN_LO, 32'h400);
        else
            wr(`OFF_CFG, cfg | 32'h10);
    endtask
    task automatic chk_pci(input logic [31:0] sba, pca, input int n);
        logic [63:0] q;
        for (int i = 0; i < n; i++)
        begin
            q = far.rd(33'(sba / 8 + i / 2));
            chk(far.pci_log.pop_front(), {pca + 4 * i, i % 2 ? q[63:32] : q[31:0]});
        end
    endtask
    task automatic t_reset;
        rd(`OFF_CFG, st);
        chk(st, 32'h1);
        rd(`OFF_STATUS, st);
        chk(st, 32'h0);
        rd(8'h40, st);
        chk(st, 32'h0);
    endtask
    task automatic t_single;
        far.mem[33'h20] = 64'h1111_2222_3333_4444;
        far.mem[33'h21] = 64'h5555_6666_7777_8888;
        prog(32'h100, 0, 32'h2000, 32'h10, 32'h0000_0104, 0);
        wait_st(32'h100);
        chk(st[9:0], 10'h100);
        chk(dma_irq, 1'b1);
        rd(`OFF_STATUS, st);
        chk(st[8], 1'b1);
        wr(`OFF_STATUS, 32'h100);
        rd(`OFF_STATUS, st);
        chk(st, 32'h0);
        chk(dma_irq, 1'b0);
        chk_pci(32'h100, 32'h2000, 4);
    endtask
    task automatic t_to_mem;
        prog(32'h300, 0, 32'h5000, 32'h8, 32'h0000_0002, 0);
        wait_st(32'h100);
        chk(dma_irq, 1'b0);
        chk(far.rd(33'h60), 64'hA5A5_5004_A5A5_5000);
    endtask
    // Descriptors sit well inside one 32-qword block
    task automatic t_chain;
        slow <= 1'b1;
        far.mem[33'h80] = 64'h440;
        far.mem[33'h81] = 64'h200;
        far.mem[33'h82] = 64'h3000;
        far.mem[33'h83] = 64'h8;
        far.mem[33'h88] = 64'h0;
        far.mem[33'h89] = 64'h208;
        far.mem[33'h8A] = 64'h3100;
        far.mem[33'h8B] = 64'h8;
        prog(0, 0, 0, 0, 32'h0000_0200, 1);
        wait_st(32'h200);
        chk(st[9:0], 10'h300);
        chk(dma_irq, 1'b1);
        rd(`OFF_CHAIN_LO, st);
        chk(st, 32'h440);
        chk_pci(32'h200, 32'h3000, 2);
        chk_pci(32'h208, 32'h3100, 2);
        slow <= 1'b0;
    endtask
    task automatic t_err(input logic [31:0] shi, cnt, input logic fm, fp, ch, input logic [4:0] e);
        fail_mem <= fm;
        fail_pci <= fp;
        prog(32'h100, shi, 32'h6000, cnt, 32'h0000_0400, ch);
        wait_st(32'h1F);
        chk(st[9:0], {5'h0, e});
        chk(dma_irq, 1'b1);
        wr(`OFF_CFG, 32'h1);
        rd(`OFF_STATUS, st);
        chk(st, 32'h0);
        fail_mem <= 1'b0;
        fail_pci <= 1'b0;
        far.pci_log.delete();
    endtask
    initial
    begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        slow = 1'b0;
        fail_mem = 1'b0;
        fail_pci = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_single;
        t_to_mem;
        t_chain;
        t_err(0, 8, 1, 0, 0, 5'h08);
        t_err(0, 8, 0, 1, 0, 5'h02);
        t_err(0, 6, 0, 0, 0, 5'h01);
        t_err(0, 0, 1, 0, 1, 5'h04);
        t_err(1, 8, 0, 0, 0, 5'h10);
        close_out;
    end
    initial
    begin
        #500000;
        error_cnt++;
        close_out;
    end
endmodule // test_pci_dma_channel
